// >>> src/pcs_pkg.sv
// Constants for the auxiliary chip-select strobe port.
// Assumes an SFR bus on the core clock and an external data bus view.
//
// Functional notes
// R1: Each pin has 2-bit function and length fields, two pins per byte.
// R2: Function 00 makes the pin a plain output driven from the port data.
// R3: Function 01 is a read strobe and 11 a read/write strobe, in range only.
// R4: Function 10 is a write strobe on external writes inside the range.
// R5: The range comes from the pin's 16-bit base and its compare length.
// R6: Each strobe pin has an 8-bit low and an 8-bit high base register.
// R7: Compare codes 00, 01, 10, 11 compare 16, 15, 14 and 8 high address bits.
// R8: A write in range drives a write strobe; 1234H at 14 bits spans four.
// R9: A strobe is active low unless its invert bit in extended control is set.
// R10: Port data drives only general-output pins; strobe pins keep strobing.
// R11: Pins 2 and 3 use the same compare-length encoding as pins 0 and 1.
// R12: Accesses above 255 go to the bus; 0 to 255 go to RAM only if enabled.
package pcs_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_BASE0_LO = 8'hB0;
  localparam logic [7:0] ADDR_BASE0_HI = 8'hB1;
  localparam logic [7:0] ADDR_BASE1_LO = 8'hB2;
  localparam logic [7:0] ADDR_BASE1_HI = 8'hB3;
  localparam logic [7:0] ADDR_BASE3_LO = 8'hB4;
  localparam logic [7:0] ADDR_BASE3_HI = 8'hB5;
  localparam logic [7:0] ADDR_BASE2_LO = 8'hB6;
  localparam logic [7:0] ADDR_BASE2_HI = 8'hB7;
  localparam logic [7:0] ADDR_CTRL_LO  = 8'hC2;
  localparam logic [7:0] ADDR_CTRL_HI  = 8'hC3;
  localparam logic [7:0] ADDR_EXT_CTRL = 8'hAE;
  localparam logic [7:0] ADDR_PORT     = 8'hD8;

  // ----------------------------------------------------------------
  // Reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [3:0]  RST_PORT     = 4'hF;
  localparam int          INV_LSB      = 4;
  localparam logic [15:0] AUX_RAM_TOP  = 16'h00FF;

  // Function field codes
  localparam logic [1:0] FN_GPIO  = 2'h0;
  localparam logic [1:0] FN_READ  = 2'h1;
  localparam logic [1:0] FN_WRITE = 2'h2;
  localparam logic [1:0] FN_RDWR  = 2'h3;

  // Compare-length masks
  localparam logic [15:0] MASK_16 = 16'hFFFF;
  localparam logic [15:0] MASK_15 = 16'hFFFE;
  localparam logic [15:0] MASK_14 = 16'hFFFC;
  localparam logic [15:0] MASK_8  = 16'hFF00;

endpackage : pcs_pkg

// >>> src/pcs_port.sv
// Auxiliary four-pin port with address-decoded chip-select strobes.
// Assumes the core drives SFR writes/reads and external data access
// strobes on clk; strobe outputs are combinational from the bus.
`timescale 1ns/1ps
module pcs_port #(
  parameter int NUM_PINS = 4
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  output logic             sfr_hit,
  input  wire logic        aux_ram_en,
  input  wire logic        xd_rd,
  input  wire logic        xd_wr,
  input  wire logic [15:0] xd_addr,
  output logic             xd_to_bus,
  output logic      [3:0]  pin_out
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  // Two control bytes hold fields for exactly four pins
  if (NUM_PINS != 4) begin : g_pin_count
    $error("pcs_port serves exactly four pins");
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] base_lo_r  [4];
  logic [7:0] base_lo_nxt[4];
  logic [7:0] base_hi_r  [4];
  logic [7:0] base_hi_nxt[4];
  logic [7:0] ctrl_lo_r, ctrl_lo_nxt;
  logic [7:0] ctrl_hi_r, ctrl_hi_nxt;
  logic [7:0] ext_ctrl_r, ext_ctrl_nxt;
  logic [3:0] port_r, port_nxt;

  // Compare mask from a compare-length code
  function automatic logic [15:0] len_mask(input logic [1:0] code);
    case (code)
      2'h0:    len_mask = pcs_pkg::MASK_16;
      2'h1:    len_mask = pcs_pkg::MASK_15;
      2'h2:    len_mask = pcs_pkg::MASK_14;
      default: len_mask = pcs_pkg::MASK_8;
    endcase
  endfunction : len_mask

  // Map a base-register address to a pin and byte half
  function automatic logic [2:0] base_sel(input logic [7:0] a);
    if (a == pcs_pkg::ADDR_BASE0_LO) base_sel = 3'h0;
    else if (a == pcs_pkg::ADDR_BASE0_HI) base_sel = 3'h1;
    else if (a == pcs_pkg::ADDR_BASE1_LO) base_sel = 3'h2;
    else if (a == pcs_pkg::ADDR_BASE1_HI) base_sel = 3'h3;
    else if (a == pcs_pkg::ADDR_BASE2_LO) base_sel = 3'h4;
    else if (a == pcs_pkg::ADDR_BASE2_HI) base_sel = 3'h5;
    else if (a == pcs_pkg::ADDR_BASE3_LO) base_sel = 3'h6;
    else base_sel = 3'h7;
  endfunction : base_sel

  // Function and compare-length fields of one pin in its control byte
  function automatic logic [1:0] fn_field(input logic [7:0] c,
                                          input logic       odd);
    fn_field = odd ? c[7:6] : c[3:2];
  endfunction : fn_field

  function automatic logic [1:0] len_field(input logic [7:0] c,
                                           input logic       odd);
    len_field = odd ? c[5:4] : c[1:0];
  endfunction : len_field

  // Strobe activity of one pin from its function code
  function automatic logic strobe_on(input logic [1:0] f,
                                     input logic       hit,
                                     input logic       rd,
                                     input logic       wr);
    case (f)
      pcs_pkg::FN_READ:  strobe_on = hit && rd; // R3
      pcs_pkg::FN_WRITE: strobe_on = hit && wr; // R4 R8
      pcs_pkg::FN_RDWR:  strobe_on = hit && (rd || wr); // R3
      default:           strobe_on = 1'b0;
    endcase
  endfunction : strobe_on

  logic is_base;
  assign is_base = (sfr_addr[7:4] == pcs_pkg::ADDR_BASE0_LO[7:4]) &&
                   (sfr_addr[3] == 1'b0);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_comb begin
    logic [2:0] s;
    s = base_sel(sfr_addr);
    for (int i = 0; i < NUM_PINS; i++) begin
      base_lo_nxt[i] = base_lo_r[i];
      base_hi_nxt[i] = base_hi_r[i];
    end
    ctrl_lo_nxt  = ctrl_lo_r;
    ctrl_hi_nxt  = ctrl_hi_r;
    ext_ctrl_nxt = ext_ctrl_r;
    port_nxt     = port_r;
    if (sfr_wr) begin
      if (is_base) begin
        if (s[0]) base_hi_nxt[s[2:1]] = sfr_wdata; // R6
        else base_lo_nxt[s[2:1]] = sfr_wdata; // R6
      end else if (sfr_addr == pcs_pkg::ADDR_CTRL_LO) begin
        ctrl_lo_nxt = sfr_wdata; // R1
      end else if (sfr_addr == pcs_pkg::ADDR_CTRL_HI) begin
        ctrl_hi_nxt = sfr_wdata; // R1
      end else if (sfr_addr == pcs_pkg::ADDR_EXT_CTRL) begin
        ext_ctrl_nxt = sfr_wdata;
      end else if (sfr_addr == pcs_pkg::ADDR_PORT) begin
        port_nxt = sfr_wdata[3:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        base_lo_r[i] <= pcs_pkg::RST_BYTE;
        base_hi_r[i] <= pcs_pkg::RST_BYTE;
      end
      ctrl_lo_r  <= pcs_pkg::RST_BYTE;
      ctrl_hi_r  <= pcs_pkg::RST_BYTE;
      ext_ctrl_r <= pcs_pkg::RST_BYTE;
      port_r     <= pcs_pkg::RST_PORT;
    end else begin
      base_lo_r  <= base_lo_nxt;
      base_hi_r  <= base_hi_nxt;
      ctrl_lo_r  <= ctrl_lo_nxt;
      ctrl_hi_r  <= ctrl_hi_nxt;
      ext_ctrl_r <= ext_ctrl_nxt;
      port_r     <= port_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  logic       hit_c;

  always_comb begin
    logic [2:0] s;
    s         = base_sel(sfr_addr);
    rdata_nxt = rdata_r;
    hit_c     = 1'b1;
    if (is_base) begin
      rdata_nxt = s[0] ? base_hi_r[s[2:1]] : base_lo_r[s[2:1]];
    end else if (sfr_addr == pcs_pkg::ADDR_CTRL_LO) begin
      rdata_nxt = ctrl_lo_r;
    end else if (sfr_addr == pcs_pkg::ADDR_CTRL_HI) begin
      rdata_nxt = ctrl_hi_r;
    end else if (sfr_addr == pcs_pkg::ADDR_EXT_CTRL) begin
      rdata_nxt = ext_ctrl_r;
    end else if (sfr_addr == pcs_pkg::ADDR_PORT) begin
      rdata_nxt = {4'h0, pin_out};
    end else begin
      rdata_nxt = pcs_pkg::RST_BYTE;
      hit_c     = 1'b0;
    end
    if (!sfr_rd) rdata_nxt = rdata_r;
  end

  always_ff @(posedge clk) begin
    if (rst) rdata_r <= pcs_pkg::RST_BYTE;
    else rdata_r <= rdata_nxt;
  end

  assign sfr_rdata = rdata_r;
  assign sfr_hit   = hit_c;

  // ----------------------------------------------------------------
  // Strobe decode and pin drive
  // ----------------------------------------------------------------
  logic [1:0] fn  [4];
  logic [1:0] len [4];

  always_comb begin
    fn[0]  = fn_field(ctrl_lo_r, 1'b0); // R1
    len[0] = len_field(ctrl_lo_r, 1'b0);
    fn[1]  = fn_field(ctrl_lo_r, 1'b1);
    len[1] = len_field(ctrl_lo_r, 1'b1);
    fn[2]  = fn_field(ctrl_hi_r, 1'b0); // R11
    len[2] = len_field(ctrl_hi_r, 1'b0);
    fn[3]  = fn_field(ctrl_hi_r, 1'b1);
    len[3] = len_field(ctrl_hi_r, 1'b1);
  end

  // Low page goes to auxiliary RAM only while it is enabled
  assign xd_to_bus = (xd_addr > pcs_pkg::AUX_RAM_TOP) || !aux_ram_en; // R12

  // Full 16-bit base address of each pin
  logic [15:0] base_w [4];

  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      base_w[i] = {base_hi_r[i], base_lo_r[i]}; // R5 R6
    end
  end

  always_comb begin
    logic [15:0] m;
    logic        hit;
    logic        act;
    m   = pcs_pkg::MASK_16;
    hit = 1'b0;
    act = 1'b0;
    for (int i = 0; i < NUM_PINS; i++) begin
      m   = len_mask(len[i]); // R7
      hit = ((xd_addr & m) == (base_w[i] & m)) && xd_to_bus; // R5
      act = strobe_on(fn[i], hit, xd_rd, xd_wr);
      if (fn[i] == pcs_pkg::FN_GPIO) pin_out[i] = port_r[i]; // R2 R10
      else pin_out[i] = act ~^ ext_ctrl_r[pcs_pkg::INV_LSB + i]; // R9
    end
  end

endmodule : pcs_port

// >>> testbench/pcs_periph.sv
// Peripheral model selected by one active-low strobe pin.
// Assumes the strobe pin is wired straight to cs_n.
`timescale 1ns/1ps
module pcs_periph (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       cs_n,
  output logic      [7:0] hits
);
  always_ff @(posedge clk)
    if (rst) hits <= 8'h00;
    else if (!cs_n) hits <= hits + 8'h01;
endmodule : pcs_periph

// >>> testbench/pcs_assertions.sv
// Port-level checker for the strobe port.
// Assumes pcs_pkg and pcs_port are compiled first.
`timescale 1ns/1ps
module pcs_chk (
  input wire logic        clk, rst, sfr_wr, sfr_rd, sfr_hit,
  input wire logic        aux_ram_en, xd_rd, xd_wr, xd_to_bus,
  input wire logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata,
  input wire logic [15:0] xd_addr,
  input wire logic [3:0]  pin_out
);
  logic [7:0]  ctl_r;
  logic        inv_r;
  logic [15:0] base_r;
  logic [15:0] msk;
  always_ff @(posedge clk)
    if (rst) {base_r, ctl_r, inv_r} <= 25'h000_0000;
    else if (sfr_wr && sfr_addr == pcs_pkg::ADDR_CTRL_LO)
      ctl_r <= sfr_wdata;
    else if (sfr_wr && sfr_addr == pcs_pkg::ADDR_EXT_CTRL)
      inv_r <= sfr_wdata[pcs_pkg::INV_LSB];
    else if (sfr_wr && sfr_addr == pcs_pkg::ADDR_BASE0_LO)
      base_r[7:0] <= sfr_wdata;
    else if (sfr_wr && sfr_addr == pcs_pkg::ADDR_BASE0_HI)
      base_r[15:8] <= sfr_wdata;
  // Compare mask of pin 0 from its length code
  always_comb
    case (ctl_r[1:0])
      2'h0:    msk = pcs_pkg::MASK_16;
      2'h1:    msk = pcs_pkg::MASK_15;
      2'h2:    msk = pcs_pkg::MASK_14;
      default: msk = pcs_pkg::MASK_8;
    endcase
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence ctl_read;
    sfr_rd && !sfr_wr && sfr_addr == pcs_pkg::ADDR_CTRL_LO;
  endsequence
  wire strb0 = ctl_r[3:2] != pcs_pkg::FN_GPIO;
  wire low_a = xd_addr <= pcs_pkg::AUX_RAM_TOP;
  sequence wr_in_range;
    ctl_r[3:2] == pcs_pkg::FN_WRITE && xd_wr && !(aux_ram_en && low_a) &&
    ((xd_addr & msk) == (base_r & msk));
  endsequence
  a_unmapped_zero: assert property (
    sfr_rd && !sfr_hit |=> sfr_rdata == 8'h00) else $error("unmapped read");
  a_ctrl_readback: assert property (
    ctl_read |=> sfr_rdata == ctl_r) else $error("control readback");
  a_high_to_bus: assert property (
    (xd_rd || xd_wr) && !low_a |-> xd_to_bus) else $error("high not on bus");
  a_ram_local: assert property (
    aux_ram_en && low_a |-> !xd_to_bus) else $error("low not to ram");
  a_reset_pins: assert property (
    $fell(rst) |-> pin_out == 4'hF) else $error("pins after reset");
  a_idle_pin: assert property (
    !xd_rd && !xd_wr && strb0 |-> pin_out[0] == !inv_r) else $error("idle");
  a_wr_only: assert property (
    ctl_r[3:2] == pcs_pkg::FN_WRITE && !xd_wr |-> pin_out[0] == !inv_r)
    else $error("write strobe fired without write");
  a_bus_gate: assert property (
    aux_ram_en && low_a && strb0 |-> pin_out[0] == !inv_r)
    else $error("strobe on ram access");
  a_wr_fires: assert property (
    wr_in_range |-> pin_out[0] == inv_r) else $error("write strobe missing");
endmodule : pcs_chk
bind pcs_port pcs_chk chk (.clk(clk), .rst(rst), .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd), .sfr_hit(sfr_hit), .aux_ram_en(aux_ram_en),
  .xd_rd(xd_rd), .xd_wr(xd_wr), .xd_to_bus(xd_to_bus), .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .xd_addr(xd_addr),
  .pin_out(pin_out));

// >>> testbench/testbench.sv
// Self-checking bench for the strobe port.
// Assumes pcs_pkg, pcs_port, the checker and the peripheral model.
`timescale 1ns/1ps
module testbench;
  logic        clk, rst, sfr_wr, sfr_rd, aux_ram_en, xd_rd, xd_wr;
  logic        sfr_hit, xd_to_bus;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, hits;
  logic [15:0] xd_addr;
  logic [3:0]  pin_out;
  logic [15:0] lim [4] = '{16'h0000, 16'h0001, 16'h0003, 16'h00FF};
  int          bad_count, cmp_count;
  pcs_port uut (.clk(clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .aux_ram_en(aux_ram_en), .xd_rd(xd_rd),
    .xd_wr(xd_wr), .xd_addr(xd_addr), .xd_to_bus(xd_to_bus),
    .pin_out(pin_out));
  pcs_periph peer (.clk(clk), .rst(rst), .cs_n(pin_out[3]), .hits(hits));
  task automatic check(input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk) #1 {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
    @(posedge clk) #1 sfr_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, exp);
    @(posedge clk) #1 {sfr_rd, sfr_addr} = {1'b1, a};
    @(posedge clk) #1 sfr_rd = 1'b0;
    check(sfr_rdata, exp);
  endtask : rd
  task automatic acc(input logic r, w, input logic [15:0] a, logic [3:0] e);
    @(posedge clk) #1 {xd_rd, xd_wr, xd_addr} = {r, w, a};
    #1 check({4'h0, pin_out}, {4'h0, e});
  endtask : acc
  task automatic complete_run;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #100000 bad_count++;
    $display("[ERR] %0t watchdog", $time);
    complete_run();
  end
  initial begin
    {rst, sfr_wr, sfr_rd, aux_ram_en, xd_rd, xd_wr} = 6'h20;
    {sfr_addr, sfr_wdata, xd_addr} = 32'h0000_0000;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    check({4'h0, pin_out}, 8'h0F);
    rd(8'h00, 8'h00);
    check({7'h00, sfr_hit}, 8'h00);
    $display("reset test done");
    wr(pcs_pkg::ADDR_BASE0_LO, 8'h34);
    wr(pcs_pkg::ADDR_BASE0_HI, 8'h12);
    wr(pcs_pkg::ADDR_CTRL_LO, 8'h0A);
    wr(pcs_pkg::ADDR_EXT_CTRL, 8'h10);
    rd(pcs_pkg::ADDR_CTRL_LO, 8'h0A);
    check({7'h00, sfr_hit}, 8'h01);
    for (int i = 0; i < 6; i++)
      acc(0, 1, 16'h1233 + 16'(i), (i > 0 && i < 5) ? 4'hF : 4'hE);
    acc(1, 0, 16'h1234, 4'hE);
    $display("write strobe test done");
    wr(pcs_pkg::ADDR_BASE3_HI, 8'h50);
    for (int c = 0; c < 4; c++) begin
      wr(pcs_pkg::ADDR_CTRL_HI, {pcs_pkg::FN_RDWR, 2'(c), 4'h0});
      acc(1, 0, 16'h5000 + lim[c], 4'h6);
      acc(0, 1, 16'h5000 + lim[c], 4'h6);
      acc(1, 0, 16'h5001 + lim[c], 4'hE);
    end
    wr(pcs_pkg::ADDR_CTRL_HI, 8'h40);
    acc(0, 1, 16'h5000, 4'hE);
    acc(1, 0, 16'h5000, 4'h6);
    $display("length test done");
    wr(pcs_pkg::ADDR_BASE3_HI, 8'h00);
    wr(pcs_pkg::ADDR_CTRL_HI, 8'hF0);
    aux_ram_en = 1'b1;
    acc(0, 1, 16'h0010, 4'hE);
    check({7'h00, xd_to_bus}, 8'h00);
    acc(1, 0, 16'h0100, 4'hE);
    check({7'h00, xd_to_bus}, 8'h01);
    @(posedge clk) #1 aux_ram_en = 1'b0;
    acc(0, 1, 16'h0010, 4'h6);
    $display("ram routing test done");
    acc(0, 0, 16'h0000, 4'hE);
    wr(pcs_pkg::ADDR_PORT, 8'h05);
    acc(0, 0, 16'h0000, 4'hC);
    wr(pcs_pkg::ADDR_CTRL_LO, 8'h00);
    acc(0, 0, 16'h0000, 4'hD);
    check({7'h00, hits == 8'h00}, 8'h00);
    $display("port data test done");
    wr(pcs_pkg::ADDR_BASE1_HI, 8'h20);
    wr(pcs_pkg::ADDR_BASE2_HI, 8'h30);
    wr(pcs_pkg::ADDR_CTRL_LO, 8'h70);
    wr(pcs_pkg::ADDR_CTRL_HI, 8'hFC);
    rd(pcs_pkg::ADDR_BASE2_HI, 8'h30);
    check({7'h00, sfr_hit}, 8'h01);
    acc(1, 0, 16'h2055, 4'hD);
    acc(0, 1, 16'h3000, 4'hB);
    wr(pcs_pkg::ADDR_EXT_CTRL, 8'h20);
    acc(1, 0, 16'h2055, 4'hF);
    rd(pcs_pkg::ADDR_PORT, 8'h0F);
    $display("pin1 pin2 test done");
    complete_run();
  end
endmodule : testbench
